/* File: hw/obd_cmd_core.v */
// Purpose: Settings, key words, linefeed, low power, protocol memory and monitor control
// Assumes: Firmware decodes host text and issues command codes over Wishbone
// Notes: Straps are caught on the first clock after reset release
//
// What this block does
// R1 - SAE byte order selected passes three data bytes unchanged; off after reset.
// R2 - Reversed byte order with J1939 swaps three data bytes; on by default.
// R3 - J1939 multiplier-one command sets timeout multiplier to one, like CAN.
// R4 - J1939 multiplier-five command sets timeout multiplier to five, like CAN.
// R5 - Keep both key words from ISO initiation and report them on request.
// R6 - Key word checking on: wrong key words fail initiation with error.
// R7 - Checking off: need two key words, ignore values, never fail on response.
// R8 - Key word checking enabled after reset.
// R9 - Linefeeds on send linefeed after each carriage return; off sends none.
// R10 - Linefeed strap sampled at reset sets linefeed default.
// R11 - After a received carriage return wait briefly for linefeed before executing.
// R12 - Low power answers OK without return, toggles power output one second later.
// R13 - Serial character or ignition rising edge or reset ends standby.
// R14 - Memory on stores each new valid protocol; off keeps saved protocol.
// R15 - Memory strap sampled at reset sets protocol memory default.
// R16 - Protocol zero means automatic search at start-up; factory setting.
// R17 - Monitor all shows every message and stays silent unless silent mode off; code hides requests after a PGN monitor, as pgn_q is not cleared.
// R18 - Stop on character or request-to-send low; finish line, STOPPED, prompt.
// R19 - The character that stops monitoring is discarded.
// R20 - For CAN, monitor all shows only messages passing filter and mask.
// R21 - Monitoring closes protocol; next request reinitialises it.
// R22 - Four-digit PGN monitor assumes leading 00, shows only matching responses.
// R23 - PGN monitor accepted only with CAN A, B or C and J1939 formatting.
`default_nettype none
`include "obd_ctl_map.vh"
module obd_cmd_core #(
    parameter integer LP_COUNT = `LP_DELAY_MS * `CLK_KHZ
) (
    input wire clk_i,
    input wire srst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire lf_strap_i,
    input wire mem_strap_i,
    input wire ignition_monitor_input,
    input wire rts_n_i,
    input wire host_rx_valid_i,
    input wire [7:0] host_rx_char_i,
    input wire kw_valid_i,
    input wire [7:0] kw_byte_i,
    input wire mon_msg_valid_i,
    input wire mon_msg_pass_i,
    input wire mon_msg_is_req_i,
    input wire mon_line_busy_i,
    output reg power_control_output,
    output reg standby_o,
    output reg monitor_active_o,
    output reg bus_silent_o,
    output reg protocol_close_o,
    output reg nv_write_o,
    output reg [3:0] nv_proto_o,
    output reg mon_show_o,
    output reg [7:0] tx_char_o,
    output reg tx_valid_o,
    input wire tx_ready_i,
    output reg cmd_exec_o,
    output reg kw_error_o,
    output reg [1:0] timer_mult_o
);
    localparam [3:0] TX_IDLE = 4'h0;
    localparam [3:0] TX_LF = 4'h1;
    localparam [3:0] TX_STOP = 4'h2;
    localparam [3:0] TX_PROMPT = 4'h3;
    localparam [3:0] TX_PROMPT_LF = 4'h4;
    localparam [3:0] TX_OK_K = 4'h5;

    reg [7:0] ctl_q;
    reg strap_pend_q;
    reg [7:0] kw1_q, kw2_q;
    reg kw_cnt_q;
    reg kw_err_q;
    reg [3:0] proto_q;
    reg [23:0] j_in_q, j_out_q;
    reg [19:0] pgn_q;
    reg mp_err_q;
    reg [1:0] ign_s_q, rts_s_q;
    reg [3:0] strap_s_q;
    reg ok_pend_q;
    reg ign_d_q;
    reg lp_wait_q;
    reg [15:0] lf_cnt_q;
    reg lf_wait_q;
    reg [3:0] tx_st_q;
    reg [3:0] stop_idx_q;
    reg stop_pend_q;
    reg tx_busy_q;
    reg [7:0] tx_req_q;
    reg tx_req_v_q;
    wire lp_done;
    wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    wire rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    wire cmd_wr = wr && wb_adr_i == `CMD_OFS;
    wire [3:0] cmd = wb_dat_i[3:0];
    wire ign_rise = ign_s_q[1] && !ign_d_q;
    wire can_j1939 = (proto_q == 4'hA || proto_q == 4'hB || proto_q == 4'hC) &&
        ctl_q[`CTL_J1939FMT_BIT];

    lp_timer #(.COUNT(LP_COUNT)) u_lp (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(cmd_wr && cmd == `CMD_LP),
        .cancel_i(1'b0),
        .done_o(lp_done)
    );

    always @(posedge clk_i) begin
        // Straps are synchronised through reset so they are settled at release
        strap_s_q <= {strap_s_q[1:0], mem_strap_i, lf_strap_i};
        if (srst_i) begin
            ign_s_q <= 2'b00;
            rts_s_q <= 2'b11;
            ign_d_q <= 1'b0;
        end else begin
            ign_s_q <= {ign_s_q[0], ignition_monitor_input};
            rts_s_q <= {rts_s_q[0], rts_n_i};
            ign_d_q <= ign_s_q[1];
        end
    end

    // Settings and commands
    always @(posedge clk_i) begin
        wb_ack_o <= 1'b0;
        protocol_close_o <= 1'b0;
        nv_write_o <= 1'b0;
        if (srst_i) begin
            ctl_q <= `CTL_RESET; // R1 R2 R8
            strap_pend_q <= 1'b1;
            timer_mult_o <= 2'd1;
            proto_q <= `PROTO_AUTO; // R16
            nv_proto_o <= `PROTO_AUTO;
            pgn_q <= 20'h0;
            mp_err_q <= 1'b0;
            monitor_active_o <= 1'b0;
            standby_o <= 1'b0;
            power_control_output <= 1'b0;
            lp_wait_q <= 1'b0;
            j_in_q <= 24'h0;
            stop_pend_q <= 1'b0;
        end else begin
            if (strap_pend_q) begin
                strap_pend_q <= 1'b0;
                ctl_q[`CTL_LF_BIT] <= strap_s_q[2]; // R10
                ctl_q[`CTL_MEM_BIT] <= strap_s_q[3]; // R15
            end
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_ack_o <= 1'b1;
            end
            if (wr && wb_adr_i == `CTL_OFS) begin
                ctl_q <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == `J1939_OFS) begin
                j_in_q <= wb_dat_i[23:0];
            end
            if (cmd_wr) begin
                case (cmd)
                    `CMD_MULT1: timer_mult_o <= 2'd1; // R3
                    `CMD_MULT5: timer_mult_o <= 2'd2; // R4
                    `CMD_LP: lp_wait_q <= 1'b1; // R12
                    `CMD_MA: begin
                        monitor_active_o <= 1'b1; // R17
                        protocol_close_o <= 1'b1; // R21
                    end
                    `CMD_MP: begin
                        if (can_j1939) begin // R23
                            monitor_active_o <= 1'b1;
                            protocol_close_o <= 1'b1; // R21
                            pgn_q <= {4'h0, 16'h0} | {4'h0, wb_dat_i[31:16]}; // R22
                            mp_err_q <= 1'b0;
                        end else begin
                            mp_err_q <= 1'b1; // R23
                        end
                    end
                    `CMD_SP: begin
                        proto_q <= wb_dat_i[7:4];
                        nv_proto_o <= wb_dat_i[7:4]; // R16
                        nv_write_o <= 1'b1;
                    end
                    `CMD_FOUND: begin
                        proto_q <= wb_dat_i[7:4];
                        if (ctl_q[`CTL_MEM_BIT]) begin // R14
                            nv_proto_o <= wb_dat_i[7:4];
                            nv_write_o <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (lp_done && lp_wait_q) begin
                lp_wait_q <= 1'b0;
                power_control_output <= ~power_control_output; // R12
                standby_o <= 1'b1;
            end
            if (standby_o && (host_rx_valid_i || ign_rise)) begin
                standby_o <= 1'b0; // R13
                power_control_output <= ~power_control_output;
            end
            if (stop_pend_q && tx_st_q == TX_STOP) begin
                stop_pend_q <= 1'b0;
            end
            if (monitor_active_o && (host_rx_valid_i || !rts_s_q[1])) begin
                monitor_active_o <= 1'b0; // R18
                stop_pend_q <= 1'b1;
            end
        end
    end

    // Byte order
    always @* begin
        if (!ctl_q[`CTL_SAE_BIT] && can_j1939) begin
            j_out_q = {j_in_q[7:0], j_in_q[15:8], j_in_q[23:16]}; // R2
        end else begin
            j_out_q = j_in_q; // R1
        end
    end

    // Key words
    always @(posedge clk_i) begin
        if (srst_i) begin
            kw1_q <= 8'h0;
            kw2_q <= 8'h0;
            kw_cnt_q <= 1'b0;
            kw_err_q <= 1'b0;
            kw_error_o <= 1'b0;
        end else begin
            kw_error_o <= 1'b0;
            if (kw_valid_i) begin
                kw_cnt_q <= ~kw_cnt_q; // R7
                if (!kw_cnt_q) begin
                    kw1_q <= kw_byte_i; // R5
                end else begin
                    kw2_q <= kw_byte_i;
                    kw_err_q <= ctl_q[`CTL_KWCHK_BIT] &&
                        (kw1_q != `KW1_EXPECT || kw_byte_i != `KW2_EXPECT); // R6 R7
                    kw_error_o <= ctl_q[`CTL_KWCHK_BIT] &&
                        (kw1_q != `KW1_EXPECT || kw_byte_i != `KW2_EXPECT); // R6
                end
            end
        end
    end

    // Monitor display and bus silence
    always @(posedge clk_i) begin
        if (srst_i) begin
            mon_show_o <= 1'b0;
            bus_silent_o <= 1'b0;
        end else begin
            bus_silent_o <= monitor_active_o && !ctl_q[`CTL_SILENT_OFF_BIT]; // R17
            mon_show_o <= monitor_active_o && mon_msg_valid_i && mon_msg_pass_i && // R20
                !(pgn_q != 20'h0 && mon_msg_is_req_i); // R22
        end
    end

    // Host command terminator and linefeed wait
    always @(posedge clk_i) begin
        if (srst_i) begin
            lf_wait_q <= 1'b0;
            lf_cnt_q <= 16'h0;
            cmd_exec_o <= 1'b0;
        end else begin
            cmd_exec_o <= 1'b0;
            if (host_rx_valid_i && !monitor_active_o && !standby_o) begin // R19
                if (host_rx_char_i == 8'h0D) begin
                    lf_wait_q <= 1'b1; // R11
                    lf_cnt_q <= 16'h0;
                end else if (host_rx_char_i == 8'h0A && lf_wait_q) begin
                    lf_wait_q <= 1'b0;
                    cmd_exec_o <= 1'b1;
                end
            end else if (lf_wait_q) begin
                if (lf_cnt_q == `LF_WAIT_CYC - 1) begin
                    lf_wait_q <= 1'b0;
                    cmd_exec_o <= 1'b1; // R11
                end else begin
                    lf_cnt_q <= lf_cnt_q + 16'h1;
                end
            end
        end
    end

    // Character output: requested chars, linefeed after CR, STOPPED and prompt
    function [7:0] stop_char;
        input [3:0] i;
        begin
            case (i)
                4'd0: stop_char = 8'h53;
                4'd1: stop_char = 8'h54;
                4'd2: stop_char = 8'h4F;
                4'd3: stop_char = 8'h50;
                4'd4: stop_char = 8'h50;
                4'd5: stop_char = 8'h45;
                4'd6: stop_char = 8'h44;
                default: stop_char = 8'h0D;
            endcase
        end
    endfunction

    always @(posedge clk_i) begin
        if (srst_i) begin
            tx_st_q <= TX_IDLE;
            tx_valid_o <= 1'b0;
            tx_char_o <= 8'h0;
            stop_idx_q <= 4'h0;
            tx_req_q <= 8'h0;
            tx_req_v_q <= 1'b0;
            ok_pend_q <= 1'b0;
        end else begin
            if (wr && wb_adr_i == `TXCH_OFS && !tx_req_v_q) begin
                tx_req_q <= wb_dat_i[7:0];
                tx_req_v_q <= 1'b1;
            end
            if (tx_valid_o && tx_ready_i) begin
                tx_valid_o <= 1'b0;
            end
            if (!tx_valid_o || tx_ready_i) begin
                case (tx_st_q)
                    TX_IDLE: begin
                        if (stop_pend_q && !mon_line_busy_i) begin // R18
                            tx_st_q <= TX_STOP;
                            stop_idx_q <= 4'h0;
                        end else if (ok_pend_q) begin // R12
                            ok_pend_q <= 1'b0;
                            tx_char_o <= 8'h4F;
                            tx_valid_o <= 1'b1;
                            tx_st_q <= TX_OK_K;
                        end else if (tx_req_v_q) begin
                            tx_req_v_q <= 1'b0;
                            tx_char_o <= tx_req_q;
                            tx_valid_o <= 1'b1;
                            if (tx_req_q == 8'h0D && ctl_q[`CTL_LF_BIT]) begin
                                tx_st_q <= TX_LF; // R9
                            end
                        end
                    end
                    TX_LF: begin
                        tx_char_o <= 8'h0A; // R9
                        tx_valid_o <= 1'b1;
                        tx_st_q <= TX_IDLE;
                    end
                    TX_STOP: begin
                        tx_char_o <= stop_char(stop_idx_q); // R18
                        tx_valid_o <= 1'b1;
                        stop_idx_q <= stop_idx_q + 4'h1;
                        if (stop_idx_q == 4'd7) begin
                            tx_st_q <= ctl_q[`CTL_LF_BIT] ? TX_PROMPT_LF : TX_PROMPT;
                        end
                    end
                    TX_PROMPT: begin
                        tx_char_o <= 8'h3E; // R18
                        tx_valid_o <= 1'b1;
                        tx_st_q <= TX_IDLE;
                    end
                    TX_PROMPT_LF: begin
                        tx_char_o <= 8'h0A; // R9
                        tx_valid_o <= 1'b1;
                        tx_st_q <= TX_PROMPT;
                    end
                    TX_OK_K: begin
                        tx_char_o <= 8'h4B; // R12
                        tx_valid_o <= 1'b1;
                        tx_st_q <= TX_IDLE;
                    end
                    default: tx_st_q <= TX_IDLE;
                endcase
            end
            // Low power answer is OK with no carriage return
            if (cmd_wr && cmd == `CMD_LP) begin
                ok_pend_q <= 1'b1; // R12
            end
        end
    end

    // Register reads
    always @(posedge clk_i) begin
        if (srst_i) begin
            wb_dat_o <= 32'h0;
        end else if (rd) begin
            case (wb_adr_i)
                `CTL_OFS: wb_dat_o <= {24'h0, ctl_q};
                `STAT_OFS: wb_dat_o <= {22'h0, tx_req_v_q, stop_pend_q, mp_err_q, kw_err_q,
                    lp_wait_q, standby_o, monitor_active_o, lf_wait_q, timer_mult_o};
                `KW_OFS: wb_dat_o <= {16'h0, kw1_q, kw2_q}; // R5
                `PROTO_OFS: wb_dat_o <= {24'h0, nv_proto_o, proto_q};
                `J1939_OFS: wb_dat_o <= {8'h0, j_out_q};
                `PGN_OFS: wb_dat_o <= {12'h0, pgn_q};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: hw/obd_ctl_map.vh */
// Purpose: Offsets, fields, reset values and timing counts of the command block
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: Included by the command core and the testbench
`ifndef OBD_CTL_MAP_VH
`define OBD_CTL_MAP_VH
`define CTL_OFS 8'h00
`define STAT_OFS 8'h04
`define KW_OFS 8'h08
`define PROTO_OFS 8'h0C
`define CMD_OFS 8'h10
`define J1939_OFS 8'h14
`define PGN_OFS 8'h18
`define TXCH_OFS 8'h1C
`define HOSTCH_OFS 8'h20
`define MONCH_OFS 8'h24
`define CMD_MULT1 4'h1
`define CMD_MULT5 4'h2
`define CMD_LP 4'h3
`define CMD_MA 4'h4
`define CMD_MP 4'h5
`define CMD_SP 4'h6
`define CMD_FOUND 4'h7
`define CMD_KW_DONE 4'h8
`define CTL_SAE_BIT 0
`define CTL_KWCHK_BIT 1
`define CTL_LF_BIT 2
`define CTL_MEM_BIT 3
`define CTL_SILENT_OFF_BIT 4
`define CTL_J1939FMT_BIT 5
`define CTL_RESET 8'h02
`define KW1_EXPECT 8'h08
`define KW2_EXPECT 8'h08
`define PROTO_AUTO 4'h0
`define LP_DELAY_MS 1000
`define CLK_KHZ 200000
`define LF_WAIT_US 2
`define LF_WAIT_CYC (`LF_WAIT_US * `CLK_KHZ / 1000)
`endif

/* File: hw/lp_timer.v */
// Purpose: Counts a delay after a start pulse and pulses done once
// Assumes: start is a one-cycle pulse on clk_i
// Notes: A new start restarts the count; cancel stops it
`default_nettype none
module lp_timer #(
    parameter integer COUNT = 200000000
) (
    input wire clk_i,
    input wire srst_i,
    input wire start_i,
    input wire cancel_i,
    output reg done_o
);
    reg [31:0] cnt_q;
    reg run_q;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (srst_i || cancel_i) begin
            run_q <= 1'b0;
            cnt_q <= 32'h0;
        end else if (start_i) begin
            run_q <= 1'b1;
            cnt_q <= 32'h0;
        end else if (run_q) begin
            if (cnt_q == COUNT - 1) begin
                run_q <= 1'b0;
                done_o <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/obd_cmd_core_monitor.sv */
// Purpose: Port-level assertions for the command core
// Assumes: Single clock, sync active-high reset
// Notes: Bound to every obd_cmd_core instance
`default_nettype none
module obd_cmd_core_monitor (
    input wire clk_i,
    input wire srst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [1:0] timer_mult_o,
    input wire mon_msg_valid_i,
    input wire mon_show_o,
    input wire monitor_active_o,
    input wire host_rx_valid_i,
    input wire cmd_exec_o,
    input wire standby_o,
    input wire power_control_output,
    input wire protocol_close_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_MULT_RANGE: assert property (timer_mult_o == 2'h1 || timer_mult_o == 2'h2)
        else $error("bad timer multiplier");
    AST_SHOW_CAUSE: assert property (mon_show_o |-> $past(mon_msg_valid_i))
        else $error("message shown without a message");
    AST_STOP_DROP: assert property (monitor_active_o && host_rx_valid_i |=> (!cmd_exec_o)[*8])
        else $error("stop character executed");
    AST_LP_TOGGLE: assert property ($rose(standby_o) |-> $changed(power_control_output))
        else $error("power output not toggled");
    AST_WAKE: assert property (standby_o && host_rx_valid_i |-> ##[1:4] !standby_o)
        else $error("standby not left on character");
    AST_CLOSE: assert property ($rose(monitor_active_o) |->
        protocol_close_o || $past(protocol_close_o) || $past(protocol_close_o, 2))
        else $error("monitor without protocol close");
    AST_IDLE_SHOW: assert property (!monitor_active_o && !$past(monitor_active_o) |-> !mon_show_o)
        else $error("message shown while not monitoring");
endmodule
bind obd_cmd_core obd_cmd_core_monitor u_obd_cmd_core_monitor (.clk_i, .srst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .timer_mult_o, .mon_msg_valid_i, .mon_show_o, .monitor_active_o,
    .host_rx_valid_i, .cmd_exec_o, .standby_o, .power_control_output, .protocol_close_o);
`default_nettype wire

/* File: sim/host_sink_model.sv */
// Purpose: Host side of the character link, collecting sent characters
// Assumes: valid/ready handshake on the rising edge
// Notes: Ready is high only every other cycle to stall the sender
`default_nettype none
module host_sink_model (
    input wire logic clk_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_char_i,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    initial tx_ready_o = 1'b0;
    always @(posedge clk_i) begin
        if (tx_valid_i === 1'b1 && tx_ready_o) begin
            q.push_back(tx_char_i);
        end
        tx_ready_o <= !tx_ready_o;
    end
endmodule
`default_nettype wire

/* File: sim/obd_interpreter_at_cmds_tb_top.sv */
// Purpose: Self-checking bench for the command core
// Assumes: Straps linefeed high, memory low; short low-power delay
// Notes: Registers reached over classic Wishbone
`default_nettype none
`include "obd_ctl_map.vh"
module obd_interpreter_at_cmds_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LPC = 20;
    logic clk_i = 0, srst_i = 1, cyc = 0, stb = 0, we = 0, ign = 0, rts_n = 1;
    logic rxv = 0, kwv = 0, mv = 0, mpass = 1, mreq = 0, mbusy = 0, rdy;
    logic [7:0] adr = 0, rxc_d = 0, kwd = 0;
    logic [31:0] wdat = 0, rdat;
    wire [31:0] dat_o;
    wire ack, pwr, stby, mact, silent, pclose, nvw, show, txv, exec, kwe;
    wire [3:0] nvp;
    wire [7:0] txc;
    wire [1:0] mult;
    int failures = 0, check_count = 0, exec_n = 0, kwe_n = 0, show_n = 0, close_n = 0, nvw_n = 0;
    obd_cmd_core #(.LP_COUNT(LPC)) u_obd_cmd_core (.clk_i(clk_i), .srst_i(srst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack), .lf_strap_i(1'b1),
        .mem_strap_i(1'b0), .ignition_monitor_input(ign), .rts_n_i(rts_n),
        .host_rx_valid_i(rxv), .host_rx_char_i(rxc_d), .kw_valid_i(kwv), .kw_byte_i(kwd),
        .mon_msg_valid_i(mv), .mon_msg_pass_i(mpass), .mon_msg_is_req_i(mreq),
        .mon_line_busy_i(mbusy), .power_control_output(pwr), .standby_o(stby),
        .monitor_active_o(mact), .bus_silent_o(silent), .protocol_close_o(pclose),
        .nv_write_o(nvw), .nv_proto_o(nvp), .mon_show_o(show), .tx_char_o(txc),
        .tx_valid_o(txv), .tx_ready_i(rdy), .cmd_exec_o(exec), .kw_error_o(kwe),
        .timer_mult_o(mult));
    host_sink_model u_host_sink_model (.clk_i(clk_i), .tx_valid_i(txv), .tx_char_i(txc),
        .tx_ready_o(rdy));
    initial forever #2.5 clk_i = !clk_i;
    always @(posedge clk_i) begin
        exec_n <= exec_n + (exec === 1'b1);
        kwe_n <= kwe_n + (kwe === 1'b1);
        show_n <= show_n + (show === 1'b1);
        close_n <= close_n + (pclose === 1'b1);
        nvw_n <= nvw_n + (nvw === 1'b1 && nvp === 4'h5);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        if (ack !== 1'b1) failures++;
        rdat = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wbx(0, a, 0);
        chk(rdat, e);
    endtask
    task automatic pulse_rx(input logic [7:0] c);
        @(posedge clk_i) rxv <= 1; rxc_d <= c;
        @(posedge clk_i) rxv <= 0;
    endtask
    task automatic kw2(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_i) kwv <= 1; kwd <= a;
        @(posedge clk_i) kwd <= b;
        @(posedge clk_i) kwv <= 0;
        tick(20);
    endtask
    task automatic msg(input logic r);
        @(posedge clk_i) mv <= 1; mreq <= r;
        @(posedge clk_i) mv <= 0;
        tick(3);
    endtask
    task automatic exp_tx(input string s);
        int n;
        n = 0;
        while (u_host_sink_model.q.size() < s.len() && n < 3000) begin
            tick(1);
            n++;
        end
        foreach (s[i]) chk(u_host_sink_model.q.size() > 0 ? u_host_sink_model.q.pop_front() : 8'hFF, s[i]);
    endtask
    task automatic t_defaults();
        rd(`CTL_OFS, 32'h00000006);
        rd(`PROTO_OFS, 32'h00000000);
        chk(mult, 2'h1);
        $display("test defaults done");
    endtask
    task automatic t_mult();
        wbx(1, `CMD_OFS, 32'h00000002);
        tick(3);
        chk(mult, 2'h2);
        wbx(1, `CMD_OFS, 32'h00000001);
        tick(3);
        chk(mult, 2'h1);
        $display("test multiplier done");
    endtask
    task automatic t_order();
        wbx(1, `CMD_OFS, 32'h000000A6);
        wbx(1, `CTL_OFS, 32'h00000026);
        wbx(1, `J1939_OFS, 32'h0000FEEE);
        rd(`J1939_OFS, 32'h00EEFE00);
        wbx(1, `CTL_OFS, 32'h00000027);
        wbx(1, `J1939_OFS, 32'h0000FEEE);
        rd(`J1939_OFS, 32'h0000FEEE);
        wbx(1, `CTL_OFS, 32'h00000026);
        $display("test byte order done");
    endtask
    task automatic t_kw();
        kw2(8'h08, 8'h08);
        chk(kwe_n, 0);
        rd(`KW_OFS, 32'h00000808);
        kw2(8'h94, 8'h08);
        chk(kwe_n, 1);
        wbx(1, `CTL_OFS, 32'h00000024);
        kw2(8'h94, 8'h55);
        chk(kwe_n, 1);
        rd(`KW_OFS, 32'h00009455);
        wbx(1, `CTL_OFS, 32'h00000026);
        $display("test key words done");
    endtask
    task automatic t_lf();
        int e;
        wbx(1, `TXCH_OFS, 32'h0000000D);
        exp_tx("\r\n");
        wbx(1, `CTL_OFS, 32'h00000022);
        wbx(1, `TXCH_OFS, 32'h0000000D);
        exp_tx("\r");
        tick(20);
        chk(u_host_sink_model.q.size(), 0);
        wbx(1, `CTL_OFS, 32'h00000026);
        e = exec_n;
        pulse_rx(8'h0D);
        tick(100);
        chk(exec_n, e);
        pulse_rx(8'h0A);
        tick(10);
        chk(exec_n, e + 1);
        pulse_rx(8'h0D);
        tick(300);
        chk(exec_n, e + 1);
        tick(150);
        chk(exec_n, e + 2);
        $display("test linefeed done");
    endtask
    task automatic t_lp();
        logic p;
        p = pwr;
        wbx(1, `CMD_OFS, 32'h00000003);
        exp_tx("OK");
        chk(stby, 1'b0);
        tick(LPC + 20);
        chk(u_host_sink_model.q.size(), 0);
        chk({stby, pwr}, {1'b1, !p});
        pulse_rx(8'h41);
        tick(10);
        chk(stby, 1'b0);
        wbx(1, `CMD_OFS, 32'h00000003);
        exp_tx("OK");
        tick(LPC + 20);
        chk(stby, 1'b1);
        @(posedge clk_i) ign <= 1;
        tick(10);
        chk(stby, 1'b0);
        ign <= 0;
        $display("test low power done");
    endtask
    task automatic t_mem();
        wbx(1, `CTL_OFS, 32'h0000002E);
        wbx(1, `CMD_OFS, 32'h00000057);
        tick(5);
        chk(nvw_n, 1);
        wbx(1, `CTL_OFS, 32'h00000026);
        wbx(1, `CMD_OFS, 32'h00000057);
        tick(5);
        chk(nvw_n, 1);
        $display("test memory done");
    endtask
    task automatic t_mon();
        int e, s;
        e = exec_n;
        wbx(1, `CMD_OFS, 32'h00000004);
        tick(5);
        chk({mact, silent}, 2'h3);
        chk(close_n, 1);
        s = show_n;
        msg(0);
        chk(show_n, s + 1);
        mpass <= 0;
        msg(0);
        chk(show_n, s + 1);
        mpass <= 1;
        mbusy <= 1;
        pulse_rx(8'h0D);
        tick(20);
        chk(u_host_sink_model.q.size(), 0);
        mbusy <= 0;
        exp_tx("STOPPED\r\n>");
        tick(500);
        chk({mact, exec_n}, {1'b0, e});
        $display("test monitor all done");
    endtask
    task automatic t_pgn();
        int s;
        wbx(1, `CMD_OFS, 32'h000000A6);
        wbx(1, `CMD_OFS, 32'hFECB0005);
        tick(5);
        chk(mact, 1'b1);
        rd(`PGN_OFS, 32'h0000FECB);
        s = show_n;
        msg(1);
        chk(show_n, s);
        msg(0);
        chk(show_n, s + 1);
        @(posedge clk_i) rts_n <= 0;
        exp_tx("STOPPED\r\n>");
        rts_n <= 1;
        wbx(1, `CMD_OFS, 32'h00000036);
        wbx(1, `CMD_OFS, 32'hFECB0005);
        tick(5);
        chk(mact, 1'b0);
        rd(`STAT_OFS, 32'h00000081);
        $display("test pgn monitor done");
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 0;
        tick(2);
        t_defaults();
        t_mult();
        t_order();
        t_kw();
        t_lf();
        t_lp();
        t_mem();
        t_mon();
        t_pgn();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
